/* File: hw/gpcw_pkg.sv */
package gpcw_pkg;
  localparam int PORT_W = 8;
  // sub-register indices held in the port address register
  localparam logic [7:0] IDX_DIR = 8'h01;
  localparam logic [7:0] IDX_ALT = 8'h02;
  localparam logic [7:0] IDX_OC = 8'h03;
  localparam logic [7:0] IDX_HDE = 8'h04;
  localparam logic [7:0] IDX_WAKE = 8'h05;
  // reset values
  localparam logic [7:0] RST_ALT_ABC = 8'h00;
  localparam logic [7:0] RST_ALT_D = 8'h01;
  localparam logic [7:0] RST_ALT_SMALL_A = 8'h04;
  localparam logic [7:0] RST_DIR_IN = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OC_D = 8'h01;
  // port identifiers
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_D = 2'h3;
  // least wake pulse width and recovery delay, in ns
  localparam int WAKE_MIN_NS = 50;
  localparam int RECOVERY_NS = 100;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + 4) / 5;
  localparam int RECOVERY_CYC = (RECOVERY_NS + 4) / 5;

  typedef enum logic [1:0] {
    GPCW_RUN = 2'b00,
    GPCW_STOP = 2'b01,
    GPCW_FILTER = 2'b10,
    GPCW_RECOVER = 2'b11
  } gpcw_state_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpcw_drive_type;
endpackage

/* File: hw/gpcw_port.sv */
`timescale 1ns/100ps
// How it works
// - alt enable 0: pin is plain I/O, direction bit sets it.
// - alt enable 1: selected peripheral function controls the pin.
// - alt enable resets 00H A-C, 01H D, 04H small-package port A.
// - index 03H selects output control through the control register.
// - output control bit 1 gives open drain, 0 push-pull.
// - open drain applies to peripheral outputs too.
// - index 04H selects high drive; bit 1 gives high current always.
// - in stop, any edge on wake-enabled pin starts the wake filter; recovery follows if it lasts.
// - too-short wake pulse does not recover, stop flag still set.
// - after recovery stop flag is set and recovery path resumes.
// - input register frozen in stop; samples the pins every cycle in run.
// - index 05H selects wake-source enables, bit 1 marks wake pin.
module gpcw_port
  import gpcw_pkg::*;
#(
  parameter logic [1:0] PORT_ID = PORT_A,
  parameter bit SMALL_PKG = 1'b0,
  parameter int MIN_CYC = WAKE_MIN_CYC,
  parameter int REC_CYC = RECOVERY_CYC
)(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ADDR_WE,
  input wire logic CTRL_WE,
  input wire logic [7:0] WDATA,
  output logic [7:0] ADDR_RDATA,
  output logic [7:0] CTRL_RDATA,
  input wire logic [7:0] PERIPH_OUT,
  input wire logic [7:0] PERIPH_OE,
  input wire logic [7:0] PLAIN_OUT,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE_N,
  output logic [7:0] HIGH_DRIVE,
  output logic [7:0] PORT_INPUT_VALUE,
  input wire logic STOP_REQ,
  output logic STOP_ACTIVE,
  output logic RECOVERY_DONE,
  output logic STOP_FLAG,
  input wire logic STOP_FLAG_CLR
);
  localparam int CW = $clog2(MIN_CYC + REC_CYC + 2);

  logic [7:0] addr_ff, dir_ff, alt_ff, oc_ff, hde_ff, wake_ff;
  logic [7:0] in_ff, ref_ff;
  logic [CW-1:0] cnt_ff;
  gpcw_state_type state_ff, nxt_state;
  gpcw_drive_type drv;
  logic [7:0] edge_hit;
  logic stop_flag_ff, done_ff;

  function automatic logic [7:0] alt_reset(input logic [1:0] id, input bit s);
    if (id == PORT_D)
      alt_reset = RST_ALT_D;
    else if (s && id == PORT_A)
      alt_reset = RST_ALT_SMALL_A;
    else
      alt_reset = RST_ALT_ABC;
  endfunction

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      addr_ff <= RST_ZERO;
    else if (ADDR_WE)
      addr_ff <= WDATA;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      dir_ff <= RST_DIR_IN;
      alt_ff <= alt_reset(PORT_ID, SMALL_PKG);
      oc_ff <= (PORT_ID == PORT_D) ? RST_OC_D : RST_ZERO;
      hde_ff <= RST_ZERO;
      wake_ff <= RST_ZERO;
    end
    else if (CTRL_WE)
    begin
      case (addr_ff)
        IDX_DIR: dir_ff <= WDATA;
        IDX_ALT: alt_ff <= WDATA;
        IDX_OC: oc_ff <= WDATA;
        IDX_HDE: hde_ff <= WDATA;
        IDX_WAKE: wake_ff <= WDATA;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (addr_ff)
      IDX_DIR: CTRL_RDATA = dir_ff;
      IDX_ALT: CTRL_RDATA = alt_ff;
      IDX_OC: CTRL_RDATA = oc_ff;
      IDX_HDE: CTRL_RDATA = hde_ff;
      IDX_WAKE: CTRL_RDATA = wake_ff;
      default: CTRL_RDATA = RST_ZERO;
    endcase
  end
  assign ADDR_RDATA = addr_ff;

  // dir bit 1 means input, as in the reset value of all-inputs
  genvar g;
  generate
    for (g = 0; g < PORT_W; g++)
    begin : g_pin
      always_comb
      begin
        if (alt_ff[g])
        begin
          drv.out[g] = PERIPH_OUT[g];
          drv.oe[g] = PERIPH_OE[g];
        end
        else
        begin
          drv.out[g] = PLAIN_OUT[g];
          drv.oe[g] = ~dir_ff[g];
        end
      end
      // open drain: a high level releases the pin
      assign PIN_OE_N[g] = ~(drv.oe[g] & ~(oc_ff[g] & drv.out[g]));
      assign PIN_OUT[g] = drv.out[g];
    end
  endgenerate

  assign HIGH_DRIVE = hde_ff;

  assign edge_hit = (PIN_IN ^ ref_ff) & wake_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      GPCW_RUN: if (STOP_REQ) nxt_state = GPCW_STOP;
      GPCW_STOP: if (|edge_hit) nxt_state = GPCW_FILTER;
      GPCW_FILTER:
        if (~|edge_hit)
          nxt_state = GPCW_STOP;
        else if (cnt_ff >= CW'(MIN_CYC - 1))
          nxt_state = GPCW_RECOVER;
      GPCW_RECOVER:
        if (cnt_ff >= CW'(REC_CYC - 1)) nxt_state = GPCW_RUN;
      default: nxt_state = GPCW_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      state_ff <= GPCW_RUN;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST || nxt_state != state_ff)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + CW'(1);
  end

  // reference level snapped on entry to stop
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      ref_ff <= RST_ZERO;
    else if (state_ff == GPCW_RUN)
      ref_ff <= PIN_IN;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      in_ff <= RST_ZERO;
    else if (state_ff == GPCW_RUN)
      in_ff <= PIN_IN;
  end
  assign PORT_INPUT_VALUE = in_ff;

  // stop flag; set wins over clear
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      stop_flag_ff <= 1'b0;
    else if ((state_ff == GPCW_FILTER && ~|edge_hit)
      || (state_ff == GPCW_RECOVER && nxt_state == GPCW_RUN))
      stop_flag_ff <= 1'b1;
    else if (STOP_FLAG_CLR)
      stop_flag_ff <= 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      done_ff <= 1'b0;
    else
      done_ff <= state_ff == GPCW_RECOVER && nxt_state == GPCW_RUN;
  end

  assign STOP_FLAG = stop_flag_ff;
  assign RECOVERY_DONE = done_ff;
  assign STOP_ACTIVE = state_ff != GPCW_RUN;
endmodule // gpcw_port

/* File: tb/gpcw_sva.sv */
`timescale 1ns/100ps
module gpcw_sva
  import gpcw_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ADDR_WE,
  input wire logic CTRL_WE,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] ADDR_RDATA,
  input wire logic [7:0] CTRL_RDATA,
  input wire logic STOP_REQ,
  input wire logic STOP_ACTIVE,
  input wire logic RECOVERY_DONE,
  input wire logic STOP_FLAG,
  input wire logic [7:0] PORT_INPUT_VALUE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence done_s;
    RECOVERY_DONE ##1 !RECOVERY_DONE;
  endsequence
  addr_wr_a:
    assert property (ADDR_WE |=> ADDR_RDATA == $past(WDATA))
    else $error("address write lost");
  sub_wr_a:
    assert property (CTRL_WE && !ADDR_WE && ADDR_RDATA inside
      {[8'h01:8'h05]} |=> CTRL_RDATA == $past(WDATA))
    else $error("sub-register write lost");
  bad_idx_a:
    assert property (!(ADDR_RDATA inside {[8'h01:8'h05]})
      |-> CTRL_RDATA == 8'h00)
    else $error("unmapped index reads nonzero");
  stop_in_a:
    assert property (STOP_REQ && !STOP_ACTIVE |=> STOP_ACTIVE)
    else $error("stop not entered");
  done_once_a:
    assert property (RECOVERY_DONE |-> done_s)
    else $error("recovery pulse too long");
  done_flag_a:
    assert property (RECOVERY_DONE |-> STOP_FLAG && !STOP_ACTIVE)
    else $error("recovery without flag");
  flag_src_a:
    assert property ($rose(STOP_FLAG) |-> $past(STOP_ACTIVE))
    else $error("flag set outside stop");
  in_frozen_a:
    assert property ($past(STOP_ACTIVE) |-> $stable(PORT_INPUT_VALUE))
    else $error("input changed in stop");
endmodule // gpcw_sva

bind gpcw_port gpcw_sva u_sva (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .ADDR_WE(ADDR_WE),
  .CTRL_WE(CTRL_WE),
  .WDATA(WDATA),
  .ADDR_RDATA(ADDR_RDATA),
  .CTRL_RDATA(CTRL_RDATA),
  .STOP_REQ(STOP_REQ),
  .STOP_ACTIVE(STOP_ACTIVE),
  .RECOVERY_DONE(RECOVERY_DONE),
  .STOP_FLAG(STOP_FLAG),
  .PORT_INPUT_VALUE(PORT_INPUT_VALUE)
);

/* File: tb/gpcw_pins.sv */
`timescale 1ns/100ps
module gpcw_pins
  import gpcw_pkg::*;
(
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en);
endmodule // gpcw_pins

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench
  import gpcw_pkg::*;
;
  logic clk = 1'h0, rst = 1'h1, aw = 1'h0, cw = 1'h0, sr = 1'h0;
  logic fc = 1'h0;
  logic [7:0] cr_small;
  logic [7:0] wd = 8'h00, po = 8'h00, poe = 8'h00, plo = 8'h00;
  logic [7:0] ext = 8'h00, exe = 8'h00;
  logic [7:0] ar, cr, pi, pout, oen, hd, piv;
  logic sa, rd, sf;
  int error_cnt = 0, compares = 0, cyc = 0;
  gpcw_port #(.PORT_ID(PORT_D), .MIN_CYC(2), .REC_CYC(3)) u_dut (
    .CLK_SYS(clk), .RST(rst), .ADDR_WE(aw), .CTRL_WE(cw), .WDATA(wd),
    .ADDR_RDATA(ar), .CTRL_RDATA(cr), .PERIPH_OUT(po), .PERIPH_OE(poe),
    .PLAIN_OUT(plo), .PIN_IN(pi), .PIN_OUT(pout), .PIN_OE_N(oen),
    .HIGH_DRIVE(hd), .PORT_INPUT_VALUE(piv), .STOP_REQ(sr),
    .STOP_ACTIVE(sa), .RECOVERY_DONE(rd), .STOP_FLAG(sf),
    .STOP_FLAG_CLR(fc));
  // second flavour only for the small-package port A reset value
  gpcw_port #(.PORT_ID(PORT_A), .SMALL_PKG(1'h1), .MIN_CYC(2), .REC_CYC(3))
    u_dut_small (
    .CLK_SYS(clk), .RST(rst), .ADDR_WE(aw), .CTRL_WE(cw), .WDATA(wd),
    .ADDR_RDATA(), .CTRL_RDATA(cr_small), .PERIPH_OUT(po),
    .PERIPH_OE(poe), .PLAIN_OUT(plo), .PIN_IN(pi), .PIN_OUT(),
    .PIN_OE_N(), .HIGH_DRIVE(), .PORT_INPUT_VALUE(), .STOP_REQ(sr),
    .STOP_ACTIVE(), .RECOVERY_DONE(), .STOP_FLAG(), .STOP_FLAG_CLR(fc));
  gpcw_pins u_pins (.pin_out(pout), .pin_oe_n(oen), .ext_val(ext),
    .ext_en(exe), .pin_in(pi));
  initial forever #2.5 clk = ~clk;
  task complete_run;
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounds a hang; the run needs under a hundred cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  task chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d, logic w);
    @(negedge clk);
    aw = 1'h1;
    wd = a;
    @(negedge clk);
    aw = 1'h0;
    cw = w;
    wd = d;
    @(negedge clk);
    cw = 1'h0;
  endtask
  task t_reset;
    wr(IDX_ALT, 8'h00, 1'h0);
    chk("alt", RST_ALT_D, cr);
    chk("altsmall", RST_ALT_SMALL_A, cr_small);
    wr(8'h06, 8'h5A, 1'h1);
    chk("bad", 8'h00, cr);
    chk("addr", 8'h06, ar);
  endtask
  task t_drive;
    wr(IDX_DIR, 8'h00, 1'h1);
    wr(IDX_ALT, 8'h00, 1'h1);
    wr(IDX_OC, 8'h00, 1'h1);
    plo = 8'hA5;
    #1 chk("pp", 8'h00, oen);
    chk("pout", 8'hA5, pout);
    wr(IDX_OC, 8'hFF, 1'h1);
    chk("od", 8'hA5, oen);
    // a peripheral sits behind every pin
    po = 8'h3C;
    poe = 8'hFF;
    wr(IDX_ALT, 8'hFF, 1'h1);
    chk("altod", 8'h3C, oen);
    chk("altout", 8'h3C, pout);
    wr(IDX_HDE, 8'hFF, 1'h1);
    chk("hd", 8'hFF, hd);
  endtask
  task t_wake;
    wr(IDX_ALT, 8'h00, 1'h1);
    wr(IDX_DIR, 8'hFF, 1'h1);
    chk("dirin", 8'hFF, oen);
    exe = 8'hFF;
    wr(IDX_WAKE, 8'h01, 1'h1);
    sr = 1'h1;
    @(negedge clk);
    sr = 1'h0;
    ext = 8'h02;
    repeat (4) @(negedge clk);
    chk("nowake", 8'h01, {7'h00, sa});
    ext = 8'h03;
    @(negedge clk);
    ext = 8'h02;
    repeat (4) @(negedge clk);
    chk("short", 8'h03, {6'h00, sa, sf});
    chk("frozen", 8'h00, piv);
    fc = 1'h1;
    @(negedge clk);
    chk("clr", 8'h00, {7'h00, sf});
    // clear held through recovery: the set at its end must win
    ext = 8'h03;
    for (int i = 0; i < 20 && rd !== 1'h1; i++) @(negedge clk);
    fc = 1'h0;
    chk("woke", 8'h05, {5'h00, rd, sa, sf});
    repeat (2) @(negedge clk);
    chk("piv", 8'h03, piv);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    t_reset;
    t_drive;
    t_wake;
    complete_run;
  end
endmodule // testbench
